// [common/vtps_regs.vh]
// Purpose: constants of the video test pattern source
// Assumes: included once per design file by bare name
// Notes: byte offsets of the register slave, packet codes, colour levels
`ifndef VTPS_REGS_VH
`define VTPS_REGS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define VTPS_OFS_CTRL 4'h0
`define VTPS_OFS_STATUS 4'h4
`define VTPS_OFS_WIDTH 4'h8
`define VTPS_OFS_HEIGHT 4'hC
`define VTPS_GO_BIT 0
`define VTPS_STATUS_BIT 0
`define VTPS_CTRL_RESET 1'b0

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define VTPS_RESP_OKAY 2'h0
`define VTPS_RESP_SLVERR 2'h2

// ----------------------------------------
// Packet codes
// ----------------------------------------
`define VTPS_TYPE_CTRL 4'hF
`define VTPS_TYPE_IMAGE 4'h0
`define VTPS_NIB_PROG 4'h0
`define VTPS_NIB_FIELD 4'h8
`define VTPS_NIB_SECOND 4'h4
`define VTPS_CTRL_BEATS 2'h3

// ----------------------------------------
// Colour levels at 8 bits
// ----------------------------------------
`define VTPS_LVL_ON 8'hB4
`define VTPS_LVL_OFF 8'h10
`define VTPS_CHROMA_MID 8'h80
`define VTPS_NUM_BARS 4'h8

`endif

// [design/vtps_geom.v]
// Purpose: border sizes and bar width for the working resolution
// Assumes: width larger than both borders
// Notes: purely combinational, read by the sequencer
`include "vtps_regs.vh"

module vtps_geom #(
   parameter HSUB = 0,
   parameter VSUB = 0
) (
   // Resolution
   input wire [15:0] width,
   // Geometry
   output wire [15:0] border_h,
   output wire [15:0] border_v,
   output wire [15:0] bar_w
);

   wire [15:0] interior;
   wire [15:0] raw_w;

   // RULE_08: two pixel sides
   // RULE_21: else one pixel
   assign border_h = (HSUB != 0) ? 16'h0002 : 16'h0001;
   // RULE_09: two line borders
   assign border_v = (VSUB != 0) ? 16'h0002 : 16'h0001;
   assign interior = width - (border_h << 1);
   // RULE_11: interior over eight
   assign raw_w = interior >> 3;
   // RULE_10: even when subsampled
   assign bar_w = (HSUB != 0) ? (raw_w & 16'hFFFE) : raw_w;

endmodule // vtps_geom

// [design/vtps_color.v]
// Purpose: pixel colour for a bar, the border or the constant field
// Assumes: BPS of at least four
// Notes: subsampled output carries Y on plane 0 and Cb/Cr alternating on plane 1
`include "vtps_regs.vh"

module vtps_color #(
   parameter BPS = 8,
   parameter YCC = 0,
   parameter HSUB = 0,
   parameter BARS = 1,
   parameter [7:0] CONST_C0 = 8'h10,
   parameter [7:0] CONST_C1 = 8'hB4,
   parameter [7:0] CONST_C2 = 8'h10
) (
   // Selection
   input wire [2:0] bar_idx,
   input wire border,
   input wire odd_x,
   // Pixel
   output wire [3*BPS-1:0] pixel
);

   reg [7:0] c0;
   reg [7:0] c1;
   reg [7:0] c2;
   reg [23:0] ycc;

   // RULE_07: truncate or promote
   // One form for both directions: MSBs kept, zeros fill below
   function [BPS-1:0] conv;
      input [7:0] v;
      reg [BPS+7:0] t;
      begin
         t = {v, {BPS{1'b0}}};
         conv = t[BPS+7:8];
      end
   endfunction

   always @* begin
      ycc = 24'h000000;
      // RULE_06: luma chroma bars
      case (bar_idx)
         3'h0: ycc = {8'hB4, 8'h80, 8'h80};
         3'h1: ycc = {8'hA2, 8'h2C, 8'h8E};
         3'h2: ycc = {8'h83, 8'h9C, 8'h2C};
         3'h3: ycc = {8'h70, 8'h48, 8'h3A};
         3'h4: ycc = {8'h54, 8'hB8, 8'hC6};
         3'h5: ycc = {8'h41, 8'h64, 8'hD4};
         3'h6: ycc = {8'h23, 8'hD4, 8'h72};
         default: ycc = {8'h10, 8'h80, 8'h80};
      endcase
      // c0/c1/c2 = B G R or Cb Y Cr
      if (border) begin
         // RULE_02: black border
         c0 = (YCC != 0) ? `VTPS_CHROMA_MID : `VTPS_LVL_OFF;
         c1 = `VTPS_LVL_OFF;
         c2 = (YCC != 0) ? `VTPS_CHROMA_MID : `VTPS_LVL_OFF;
      end else if (BARS == 0) begin
         // RULE_01: constant colour
         c0 = CONST_C0;
         c1 = CONST_C1;
         c2 = CONST_C2;
      end else if (YCC != 0) begin
         c0 = ycc[15:8];
         c1 = ycc[23:16];
         c2 = ycc[7:0];
      end else begin
         // RULE_04: green, red, blue toggles
         // RULE_05: 180 on, 16 off
         c1 = !bar_idx[2] ? `VTPS_LVL_ON : `VTPS_LVL_OFF;
         c2 = !bar_idx[1] ? `VTPS_LVL_ON : `VTPS_LVL_OFF;
         c0 = !bar_idx[0] ? `VTPS_LVL_ON : `VTPS_LVL_OFF;
      end
   end

   // RULE_19: RGB never subsampled
   assign pixel = (YCC != 0 && HSUB != 0) ?
      {{BPS{1'b0}}, conv(odd_x ? c2 : c0), conv(c1)} :
      {conv(c2), conv(c1), conv(c0)};

endmodule // vtps_color

// [design/vtps_top.v]
// Purpose: video test pattern source with AXI4-Lite run-time control
// Assumes: one clock, synchronous active-low reset, BPS of at least four
// Notes: one pixel per beat, three planes in parallel
`include "vtps_regs.vh"

// Summary of operation
// RULE_01: Pattern is a build-time constant colour or vertical colour bars.
// RULE_02: A black border surrounds the image on all four edges.
// RULE_03: Eight bars at 75%: white yellow cyan green magenta red blue black.
// RULE_04: Green on for bars one to four, red toggles per two, blue per one.
// RULE_05: RGB at 8 bits uses 180 for on and 16 for off.
// RULE_06: Luma chroma bars use the fixed Y,Cb,Cr table values.
// RULE_07: Other sample widths truncate or promote the 8-bit value.
// RULE_08: Horizontally subsampled luma chroma gets two pixel side borders.
// RULE_09: Vertically subsampled output gets two line top and bottom borders.
// RULE_10: Subsampled output keeps every bar width even.
// RULE_11: Seven bars take interior width over eight; black bar takes rest.
// RULE_12: A control packet with the resolution precedes every image packet.
// RULE_13: Interlaced fields come in pairs, order set by field synchronisation.
// RULE_14: New resolution takes effect only at a frame or field-pair boundary.
// RULE_15: At each boundary status drops to zero, wait go, copy settings.
// RULE_16: Then status is one and one or two packet sets are sent.
// RULE_17: Output advances only when downstream accepts, never losing data.
// RULE_18: Software must not set an odd height when interlaced or subsampled.
// RULE_19: Chroma subsampling applies to luma chroma only; RGB is full.
// RULE_20: Software must not exceed the build-time width and height.
// RULE_21: Without subsampling a border is one pixel on each side.
// RULE_22: Field order, pattern and constant colour are build-time choices.
module vtps_top #(
   parameter BPS = 8,
   parameter [15:0] MAX_W = 16'h0280,
   parameter [15:0] MAX_H = 16'h01E0,
   parameter INTERLACED = 0,
   parameter SYNC_FIRST = 0,
   parameter YCC = 0,
   parameter SUBSAMP = 0,
   parameter BARS = 1,
   parameter RUNTIME_CTRL = 1,
   parameter [7:0] CONST_C0 = 8'h10,
   parameter [7:0] CONST_C1 = 8'hB4,
   parameter [7:0] CONST_C2 = 8'h10
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Pixel stream
   output reg [3*BPS-1:0] dout_data,
   output reg dout_valid,
   output reg dout_sop,
   output reg dout_eop,
   input wire dout_ready
);

   // ----------------------------------------
   // Constants
   // ----------------------------------------
   // RULE_19: subsampling only for luma chroma
   localparam HSUB = (YCC != 0 && SUBSAMP != 0) ? 1 : 0;
   localparam VSUB = (YCC != 0 && SUBSAMP == 2 && INTERLACED == 0) ? 1 : 0;
   localparam ST_WAIT = 3'h0;
   localparam ST_CHDR = 3'h1;
   localparam ST_CDAT = 3'h2;
   localparam ST_IHDR = 3'h3;
   localparam ST_PIX = 3'h4;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg go;
   reg status;
   reg [15:0] width_sw;
   reg [15:0] height_sw;
   reg [15:0] width_act;
   reg [15:0] height_act;
   reg [3:0] awaddr_q;
   reg aw_held;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_held;
   reg [2:0] state;
   reg [1:0] cbeat;
   reg field_cnt;
   reg second_type;
   reg [15:0] x;
   reg [15:0] y;
   reg [15:0] bar_cnt;
   reg [2:0] bar_idx;
   reg [31:0] rd_word;
   reg rd_hit;
   wire adv;
   wire go_eff;
   wire [15:0] lines;
   wire [15:0] border_h;
   wire [15:0] border_v;
   wire [15:0] bar_w;
   wire in_border;
   wire last_x;
   wire last_y;
   wire [3:0] lace_nib;
   wire [3*BPS-1:0] pixel;

   // Three nibbles, one in the low bits of each plane
   function [3*BPS-1:0] nib3;
      input [3:0] a;
      input [3:0] b;
      input [3:0] c;
      begin
         nib3 = {{(BPS-4){1'b0}}, c, {(BPS-4){1'b0}}, b, {(BPS-4){1'b0}}, a};
      end
   endfunction

   // ----------------------------------------
   // Register slave
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `VTPS_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         go <= `VTPS_CTRL_RESET;
         width_sw <= MAX_W;
         height_sw <= MAX_H;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `VTPS_RESP_OKAY;
            case (awaddr_q)
               `VTPS_OFS_CTRL: begin
                  if (wstrb_q[0]) begin
                     go <= wdata_q[`VTPS_GO_BIT];
                  end
               end
               `VTPS_OFS_STATUS: begin
                  // Read-only, write ignored
               end
               `VTPS_OFS_WIDTH: begin
                  if (wstrb_q[0]) width_sw[7:0] <= wdata_q[7:0];
                  if (wstrb_q[1]) width_sw[15:8] <= wdata_q[15:8];
               end
               `VTPS_OFS_HEIGHT: begin
                  if (wstrb_q[0]) height_sw[7:0] <= wdata_q[7:0];
                  if (wstrb_q[1]) height_sw[15:8] <= wdata_q[15:8];
               end
               default: begin
                  s_axi_bresp <= `VTPS_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   always @* begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `VTPS_OFS_CTRL: rd_word = {31'h00000000, go};
         `VTPS_OFS_STATUS: rd_word = {31'h00000000, status};
         `VTPS_OFS_WIDTH: rd_word = {16'h0000, width_sw};
         `VTPS_OFS_HEIGHT: rd_word = {16'h0000, height_sw};
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `VTPS_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `VTPS_RESP_OKAY : `VTPS_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Geometry and colour
   // ----------------------------------------
   vtps_geom #(
      .HSUB(HSUB),
      .VSUB(VSUB)
   ) u_geom (
      .width(width_act),
      .border_h(border_h),
      .border_v(border_v),
      .bar_w(bar_w)
   );

   // RULE_03: eight bars in order
   vtps_color #(
      .BPS(BPS),
      .YCC(YCC),
      .HSUB(HSUB),
      .BARS(BARS),
      .CONST_C0(CONST_C0),
      .CONST_C1(CONST_C1),
      .CONST_C2(CONST_C2)
   ) u_color (
      .bar_idx(bar_idx),
      .border(in_border),
      .odd_x(x[0]),
      .pixel(pixel)
   );

   // Odd heights lose the last line when interlaced
   assign lines = (INTERLACED != 0) ? (height_act >> 1) : height_act;
   assign in_border = (x < border_h) || (x >= width_act - border_h) ||
                      (y < border_v) || (y >= lines - border_v);
   assign last_x = (x == width_act - 16'h0001);
   assign last_y = (y == lines - 16'h0001);
   assign lace_nib = (INTERLACED != 0) ?
      (second_type ? (`VTPS_NIB_FIELD | `VTPS_NIB_SECOND) : `VTPS_NIB_FIELD) :
      `VTPS_NIB_PROG;
   // RULE_17: move only on acceptance
   assign adv = !dout_valid || dout_ready;
   // Without run-time control the source free-runs
   assign go_eff = (RUNTIME_CTRL != 0) ? go : 1'b1;

   // ----------------------------------------
   // Packet sequencer
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_WAIT;
         status <= 1'b0;
         width_act <= MAX_W;
         height_act <= MAX_H;
         cbeat <= 2'h0;
         field_cnt <= 1'b0;
         second_type <= 1'b0;
         x <= 16'h0000;
         y <= 16'h0000;
         bar_cnt <= 16'h0000;
         bar_idx <= 3'h0;
         dout_valid <= 1'b0;
         dout_data <= {3*BPS{1'b0}};
         dout_sop <= 1'b0;
         dout_eop <= 1'b0;
      end else begin
         case (state)
            ST_WAIT: begin
               // RULE_15: status low, wait go
               status <= 1'b0;
               if (adv) begin
                  dout_valid <= 1'b0;
               end
               if (go_eff) begin
                  // RULE_14: latch only here
                  if (RUNTIME_CTRL != 0) begin
                     width_act <= width_sw;
                     height_act <= height_sw;
                  end
                  // RULE_16: status high, send
                  status <= 1'b1;
                  field_cnt <= 1'b0;
                  // RULE_13 RULE_22: build-time pair order
                  second_type <= (SYNC_FIRST != 0);
                  state <= ST_CHDR;
               end
            end
            ST_CHDR: begin
               if (adv) begin
                  // RULE_12: control packet first
                  dout_valid <= 1'b1;
                  dout_data <= nib3(`VTPS_TYPE_CTRL, 4'h0, 4'h0);
                  dout_sop <= 1'b1;
                  dout_eop <= 1'b0;
                  cbeat <= 2'h0;
                  state <= ST_CDAT;
               end
            end
            ST_CDAT: begin
               if (adv) begin
                  dout_valid <= 1'b1;
                  dout_sop <= 1'b0;
                  case (cbeat)
                     2'h0: dout_data <= nib3(width_act[15:12], width_act[11:8],
                                             width_act[7:4]);
                     2'h1: dout_data <= nib3(width_act[3:0], height_act[15:12],
                                             height_act[11:8]);
                     default: dout_data <= nib3(height_act[7:4], height_act[3:0],
                                                lace_nib);
                  endcase
                  dout_eop <= (cbeat == `VTPS_CTRL_BEATS - 2'h1);
                  cbeat <= cbeat + 2'h1;
                  if (cbeat == `VTPS_CTRL_BEATS - 2'h1) begin
                     state <= ST_IHDR;
                  end
               end
            end
            ST_IHDR: begin
               if (adv) begin
                  dout_valid <= 1'b1;
                  dout_data <= nib3(`VTPS_TYPE_IMAGE, 4'h0, 4'h0);
                  dout_sop <= 1'b1;
                  dout_eop <= 1'b0;
                  x <= 16'h0000;
                  y <= 16'h0000;
                  bar_cnt <= 16'h0000;
                  bar_idx <= 3'h0;
                  state <= ST_PIX;
               end
            end
            ST_PIX: begin
               if (adv) begin
                  dout_valid <= 1'b1;
                  dout_data <= pixel;
                  dout_sop <= 1'b0;
                  dout_eop <= last_x && last_y;
                  // RULE_11: black bar takes rest
                  if (x < border_h) begin
                     bar_cnt <= 16'h0000;
                     bar_idx <= 3'h0;
                  end else if (bar_cnt == bar_w - 16'h0001 && bar_idx != 3'h7) begin
                     bar_cnt <= 16'h0000;
                     bar_idx <= bar_idx + 3'h1;
                  end else begin
                     bar_cnt <= bar_cnt + 16'h0001;
                  end
                  if (last_x) begin
                     x <= 16'h0000;
                     y <= y + 16'h0001;
                  end else begin
                     x <= x + 16'h0001;
                  end
                  if (last_x && last_y) begin
                     // RULE_16: second field of the pair
                     if (INTERLACED != 0 && !field_cnt) begin
                        field_cnt <= 1'b1;
                        second_type <= !second_type;
                        state <= ST_CHDR;
                     end else begin
                        // RULE_15: status drops at boundary
                        status <= 1'b0;
                        state <= ST_WAIT;
                     end
                  end
               end
            end
            default: begin
               state <= ST_WAIT;
            end
         endcase
      end
   end

endmodule // vtps_top

// [bench/vtps_properties.sv]
// Purpose: stream and bus properties of the pattern source
// Assumes: bound to vtps_top, one clock, 8-bit samples
// Notes: helper logic tracks packet kind and beat number
module vtps_properties #(
   parameter BPS = 8
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // Pixel stream
   input wire [3*BPS-1:0] dout_data,
   input wire dout_valid,
   input wire dout_sop,
   input wire dout_eop,
   input wire dout_ready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg in_ctrl;
   reg [3:0] beat_n;
   sequence s_taken;
      dout_valid && dout_ready;
   endsequence
   sequence s_stall;
      dout_valid && !dout_ready;
   endsequence
   // Saturates so long image packets never wrap
   always @(posedge aclk) begin
      if (!aresetn) begin
         in_ctrl <= 1'b0;
         beat_n <= 4'h0;
      end else if (dout_valid && dout_ready) begin
         in_ctrl <= dout_sop ? (dout_data[3:0] == 4'hF) : in_ctrl;
         beat_n <= dout_sop ? 4'h1 : (beat_n == 4'hF ? beat_n : beat_n + 4'h1);
      end
   end
   a_stall_hold: assert property (s_stall |=> dout_valid && $stable(dout_data)
      && $stable(dout_sop) && $stable(dout_eop)) else $error("beat changed under stall");
   a_sop_type: assert property (s_taken ##0 dout_sop |->
      dout_data[3:0] == 4'hF || dout_data[3:0] == 4'h0) else $error("bad packet type");
   a_ctrl_first: assert property (s_taken ##0 (dout_sop && dout_data[3:0] == 4'h0)
      |-> in_ctrl && beat_n == 4'h4) else $error("image without control packet");
   a_ctrl_len: assert property (s_taken ##0 (in_ctrl && !dout_sop && beat_n == 4'h3)
      |-> dout_eop) else $error("control packet length");
   a_top_black: assert property (s_taken ##0 (!in_ctrl && !dout_sop && beat_n == 4'h1)
      |-> dout_data == {3{8'h10}}) else $error("first pixel not black");
   a_eop_next_sop: assert property (s_taken ##0 dout_eop |=> !dout_valid || dout_sop)
      else $error("no start after end of packet");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not released");
endmodule // vtps_properties

bind vtps_top vtps_properties #(.BPS(BPS)) i_vtps_properties (.aclk(aclk), .aresetn(aresetn),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .dout_data(dout_data), .dout_valid(dout_valid), .dout_sop(dout_sop), .dout_eop(dout_eop),
   .dout_ready(dout_ready));

// [bench/vtps_sink.sv]
// Purpose: downstream receiver of the pixel stream
// Assumes: one clock shared with the source
// Notes: stall drops ready one cycle in four; accepted beats kept as {sop,eop,data}
module vtps_sink #(
   parameter W = 24
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Stream
   input wire [W-1:0] dout_data,
   input wire dout_valid,
   input wire dout_sop,
   input wire dout_eop,
   output logic dout_ready,
   // Mode
   input wire stall
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [W+1:0] beats[$];
   logic [1:0] phase;
   always @(posedge aclk) begin
      if (!aresetn) begin
         dout_ready <= 1'b0;
         phase <= 2'h0;
      end else begin
         if (dout_valid && dout_ready) beats.push_back({dout_sop, dout_eop, dout_data});
         phase <= phase + 2'h1;
         dout_ready <= !stall || phase != 2'h0;
      end
   end
endmodule // vtps_sink

// [bench/vtps_top_test.sv]
// Purpose: self-checking bench of the pattern source
// Assumes: RGB, progressive, bars, 8-bit samples, 32x8 maximum
// Notes: frames are compared beat by beat against values worked out here
`include "vtps_regs.vh"
`define CHECK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
   $display("mismatch at %0t: got %h expected %h", $time, a, e); end end

module vtps_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b1;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [23:0] dout_data;
   logic dout_valid, dout_sop, dout_eop, dout_ready;
   int n_mismatch = 0, tests_run = 0;

   always #2.5 aclk = ~aclk;

   vtps_top #(.MAX_W(16'h0020), .MAX_H(16'h0008)) i_vtps_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .dout_data(dout_data),
      .dout_valid(dout_valid), .dout_sop(dout_sop), .dout_eop(dout_eop), .dout_ready(dout_ready));

   vtps_sink #(.W(24)) i_vtps_sink (.aclk(aclk), .aresetn(aresetn), .dout_data(dout_data),
      .dout_valid(dout_valid), .dout_sop(dout_sop), .dout_eop(dout_eop),
      .dout_ready(dout_ready), .stall(stall));

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHECK({s_axi_rresp, s_axi_rdata}, {r, d})
   endtask

   // ----------------------------------------
   // Frame expectations
   // ----------------------------------------
   function automatic logic [23:0] px(input int x, input int y, input int w, input int h);
      int k;
      if (x == 0 || y == 0 || x == w - 1 || y == h - 1) return {3{8'h10}};
      k = (x - 1) / ((w - 2) >> 3);
      if (k > 7) k = 7;
      return {(k[1] ? 8'h10 : 8'hB4), (k[2] ? 8'h10 : 8'hB4), (k[0] ? 8'h10 : 8'hB4)};
   endfunction

   task automatic wait_beats(input int n);
      while (i_vtps_sink.beats.size() < n) @(posedge aclk);
   endtask

   task automatic chk_frame(input int w, input int h);
      logic [25:0] b;
      logic [35:0] nib;
      logic [11:0] c;
      nib = {w[15:0], h[15:0], 4'h0};
      b = i_vtps_sink.beats.pop_front();
      `CHECK({b[25], b[3:0]}, {1'b1, 4'hF})
      for (int k = 0; k < 3; k++) begin
         b = i_vtps_sink.beats.pop_front();
         c = nib[35 - 12 * k -: 12];
         `CHECK({b[24], b[19:16], b[11:8], b[3:0]}, {k == 2, c[3:0], c[7:4], c[11:8]})
      end
      b = i_vtps_sink.beats.pop_front();
      `CHECK({b[25], b[3:0]}, {1'b1, 4'h0})
      for (int y = 0; y < h; y++) begin
         for (int x = 0; x < w; x++) begin
            b = i_vtps_sink.beats.pop_front();
            `CHECK(b, {1'b0, x == w - 1 && y == h - 1, px(x, y, w, h)})
         end
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      logic [1:0] r;
      rd_chk(`VTPS_OFS_CTRL, 32'h0, `VTPS_RESP_OKAY);
      rd_chk(`VTPS_OFS_WIDTH, 32'h20, `VTPS_RESP_OKAY);
      rd_chk(`VTPS_OFS_HEIGHT, 32'h8, `VTPS_RESP_OKAY);
      wr(`VTPS_OFS_STATUS, 32'h1, r);
      `CHECK(r, `VTPS_RESP_OKAY)
      rd_chk(`VTPS_OFS_STATUS, 32'h0, `VTPS_RESP_OKAY);
      wr(4'h6, 32'h1, r);
      `CHECK(r, `VTPS_RESP_SLVERR)
      rd_chk(4'h2, 32'h0, `VTPS_RESP_SLVERR);
      $display("t_regs done");
   endtask

   // Resize lands mid-frame, so only the next frame may use it
   task automatic t_frames;
      logic [1:0] r;
      wr(`VTPS_OFS_CTRL, 32'h1, r);
      rd_chk(`VTPS_OFS_STATUS, 32'h1, `VTPS_RESP_OKAY);
      wr(`VTPS_OFS_WIDTH, 32'h14, r);
      wr(`VTPS_OFS_HEIGHT, 32'h6, r);
      wait_beats(261);
      wr(`VTPS_OFS_CTRL, 32'h0, r);
      stall <= 1'b0;
      chk_frame(32, 8);
      wait_beats(125);
      chk_frame(20, 6);
      $display("t_frames done");
   endtask

   task automatic t_idle;
      repeat (60) @(posedge aclk);
      rd_chk(`VTPS_OFS_STATUS, 32'h0, `VTPS_RESP_OKAY);
      `CHECK(i_vtps_sink.beats.size(), 0)
      $display("t_idle done");
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_frames();
      t_idle();
      test_done();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      test_done();
   end
endmodule // vtps_top_test
